// ---- rtl/ccs_sequencer.sv ----
// Purpose: chopped conversion sequencer with excitation source config
// Assumes: APB slave, modulator clock and trigger arrive on pins
// Notes: one modulator period is one synchronised rising edge of modClk
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - a sequence starts on a trigger rising edge or on a start command.
// - the settling delay is added to each of the two conversions of a chopped pair.
// - chopped low-latency first results take 208130 down to 208 periods, later ones half.
// - chopped sinc3 first results take 614530 down to 464 periods, later ones half.
// - input polarity reverses before every conversion after the first.
// - each output is the average of the two latest opposite-polarity results.
// - the chopped rate drops by resettling while the filter notch timing is kept.
// - a four-bit magnitude field sets both matched sources.
// - two four-bit route fields steer each source to any input.
// - both sources may share one pin without any conflict.
// - chopping is enabled by a bit in the data rate register.
// - in continuous chopping each later result takes half the first.
module ccs_sequencer
   import ccs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic convTrigger,
   input wire logic modClk,
   input wire logic startCmd,
   input wire logic [23:0] convData,
   input wire logic refEnable,
   output logic polarityInv,
   output logic convActive,
   output logic dataReady,
   output logic [23:0] chopResult,
   output logic [3:0] excite_magnitude,
   output logic [3:0] excite_source_one,
   output logic [3:0] excite_source_two
);
   import ccs_pkg::*;

   // ****************************************
   // constants and functions
   // ****************************************
   localparam logic [19:0] SINC3_FIRST [RATE_NUM] = '{
      20'd614530, 20'd307330, 20'd153730, 20'd92290, 20'd76930, 20'd30850,
      20'd25714, 20'd15490, 20'd7810, 20'd3970, 20'd2050, 20'd1616, 20'd848,
      20'd464};
   localparam logic [19:0] LOWLAT_FIRST [RATE_NUM] = '{
      20'd208130, 20'd105730, 20'd54530, 20'd30850, 20'd28930, 20'd10320,
      20'd8658, 20'd5200, 20'd2640, 20'd1360, 20'd720, 20'd592, 20'd336,
      20'd208};

   function automatic logic [19:0] firstPeriods(input logic sinc3, input logic [3:0] rate);
      logic [3:0] r;
      r = (rate > RATE_4000) ? RATE_4000 : rate;
      firstPeriods = sinc3 ? SINC3_FIRST[r] : LOWLAT_FIRST[r];
   endfunction

   function automatic logic [19:0] delayPeriods(input logic [2:0] code);
      delayPeriods = (code == 3'h0) ? DELAY_DEF : (DELAY_DEF << code);
   endfunction

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] regGain, regRate, regExc1, regExc2;
   logic seqStart, lastPol, chopOn, contMode;
   ccs_state_t state;
   logic [19:0] periodCnt, target, delayCnt;
   logic [23:0] resA, resB;
   logic [3:0] nConv;
   logic trigLevel, trigRise, modLevel, modRise;
   logic apbAccess;
   logic [19:0] next_target;

   ccs_pin_sync uTrig (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
      .pinIn(convTrigger), .level(trigLevel), .rise(trigRise));
   ccs_pin_sync uMod (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
      .pinIn(modClk), .level(modLevel), .rise(modRise));

   assign apbAccess = psel && penable;
   assign chopOn = regRate[CHOP_BIT];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regGain <= GAIN_RST;
         regRate <= RATE_RST;
         regExc1 <= EXC1_RST;
         regExc2 <= EXC2_RST;
         contMode <= 1'b0;
      end else if (clkEn && apbAccess && pwrite) begin
         unique case (paddr)
            ADDR_GAIN: regGain <= pwdata[7:0];
            ADDR_RATE: regRate <= pwdata[7:0];
            ADDR_EXC1: regExc1 <= pwdata[7:0];
            ADDR_EXC2: regExc2 <= pwdata[7:0];
            ADDR_CTRL: contMode <= pwdata[1];
            default: ;
         endcase
      end
   end

   // ****************************************
   // apb read path, zero wait states
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            unique case (paddr)
               ADDR_GAIN: prdata[7:0] <= regGain;
               ADDR_RATE: prdata[7:0] <= regRate;
               ADDR_EXC1: prdata[7:0] <= regExc1;
               ADDR_EXC2: prdata[7:0] <= regExc2;
               ADDR_CTRL: prdata[1] <= contMode;
               ADDR_STAT: prdata[7:0] <= {nConv, state};
               ADDR_RESA: prdata[23:0] <= resA;
               ADDR_RESB: prdata[23:0] <= resB;
               ADDR_OUT: prdata[23:0] <= chopResult;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // start request: pin edge or command pulse
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         seqStart <= 1'b0;
      end else if (clkEn) begin
         seqStart <= trigRise || startCmd || (apbAccess && pwrite && paddr == ADDR_CTRL
            && pwdata[0]);
      end
   end

   // ****************************************
   // conversion timing
   // ****************************************
   // every chopped conversion, first pair included, runs half the tabulated first period
   always_comb begin
      next_target = firstPeriods(regRate[FILT_BIT], regRate[3:0]);
      next_target = next_target >> 1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         periodCnt <= 20'h00000;
         delayCnt <= 20'h00000;
         target <= 20'h00000;
         convActive <= 1'b0;
         polarityInv <= 1'b0;
         lastPol <= 1'b0;
         dataReady <= 1'b0;
         resA <= 24'h000000;
         resB <= 24'h000000;
         chopResult <= 24'h000000;
         nConv <= 4'h0;
      end else if (clkEn) begin
         dataReady <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (seqStart) begin
                  state <= ST_FIRST;
                  target <= firstPeriods(regRate[FILT_BIT], regRate[3:0]) >> 1;
                  delayCnt <= delayPeriods(regGain[DELAY_LSB +: 3]);
                  periodCnt <= 20'h00000;
                  polarityInv <= 1'b0;
                  convActive <= 1'b1;
                  nConv <= 4'h0;
               end
            end
            ST_FIRST, ST_SECOND, ST_NEXT: begin
               if (modRise) begin
                  if (delayCnt != 20'h00000) begin
                     delayCnt <= delayCnt - 20'h00001;
                  end else if (periodCnt + 20'h00001 >= target) begin
                     periodCnt <= 20'h00000;
                     lastPol <= polarityInv;
                     if (polarityInv) begin
                        resB <= convData;
                     end else begin
                        resA <= convData;
                     end
                     nConv <= nConv + 4'h1;
                     if (!chopOn) begin
                        chopResult <= convData;
                        dataReady <= 1'b1;
                        convActive <= contMode;
                        state <= contMode ? ST_NEXT : ST_IDLE;
                        target <= next_target << 1;
                     end else begin
                        polarityInv <= ~polarityInv;
                        delayCnt <= delayPeriods(regGain[DELAY_LSB +: 3]);
                        target <= next_target;
                        if (state != ST_FIRST) begin
                           chopResult <= avgPair(polarityInv ? resA : convData,
                              polarityInv ? convData : resB);
                           dataReady <= 1'b1;
                           if (!contMode) begin
                              state <= ST_IDLE;
                              convActive <= 1'b0;
                           end else begin
                              state <= ST_NEXT;
                           end
                        end else begin
                           state <= ST_SECOND;
                        end
                     end
                  end else begin
                     periodCnt <= periodCnt + 20'h00001;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   function automatic logic [23:0] avgPair(input logic [23:0] a, input logic [23:0] b);
      logic [24:0] s;
      // inverted-polarity result is negated before averaging
      s = {a[23], a} - {b[23], b};
      avgPair = s[24:1];
   endfunction

   // ****************************************
   // excitation sources
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         excite_magnitude <= MAG_OFF;
         excite_source_one <= ROUTE_OFF;
         excite_source_two <= ROUTE_OFF;
      end else if (clkEn) begin
         excite_magnitude <= refEnable ? regExc1[3:0] : MAG_OFF;
         excite_source_one <= regExc2[3:0];
         excite_source_two <= regExc2[7:4];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // a frozen clock enable holds dataReady without a new completion
   sequence s_pair_done;
      dataReady && chopOn && $past(clkEn);
   endsequence

   a_route_shared: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && regExc2[3:0] == regExc2[7:4]) |=> (excite_source_one == excite_source_two))
      else $error("shared route rejected");
   a_mag_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && refEnable) |=> (excite_magnitude == $past(regExc1[3:0])))
      else $error("magnitude not applied");
   a_polarity_flip: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_pair_done |-> (polarityInv != $past(polarityInv)))
      else $error("polarity did not reverse");
   a_start_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && state == ST_IDLE && seqStart) |=> convActive)
      else $error("start ignored");
   a_chop_avg: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_pair_done |-> (lastPol != $past(lastPol)))
      else $error("average without pair");
   a_no_first_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (chopOn && state == ST_SECOND) |-> !dataReady)
      else $error("output after one chopped conversion");
endmodule // ccs_sequencer

// ---- rtl/ccs_pkg.sv ----
// Purpose: constants for the chopped conversion sequencer
// Assumes: 100 MHz system clock, 4.096 MHz modulator clock supplied as a pin
// Notes: all offsets, the delay, chop and filter fields and the register resets except CTRL live here; the period tables live in ccs_sequencer
package ccs_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_GAIN = 8'h0C;
   localparam logic [7:0] ADDR_RATE = 8'h10;
   localparam logic [7:0] ADDR_EXC1 = 8'h18;
   localparam logic [7:0] ADDR_EXC2 = 8'h1C;
   localparam logic [7:0] ADDR_CTRL = 8'h40;
   localparam logic [7:0] ADDR_STAT = 8'h44;
   localparam logic [7:0] ADDR_RESA = 8'h48;
   localparam logic [7:0] ADDR_RESB = 8'h4C;
   localparam logic [7:0] ADDR_OUT = 8'h50;
   // printed register indices
   localparam int IDX_GAIN = 3;
   localparam int IDX_RATE = 4;
   localparam int IDX_EXC1 = 6;
   localparam int IDX_EXC2 = 7;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int DELAY_LSB = 5;
   localparam int CHOP_BIT = 7;
   localparam int FILT_BIT = 4;
   localparam int RATE_LSB = 0;
   localparam int REFEN_BIT = 4;
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h14;
   localparam logic [7:0] EXC1_RST = 8'h00;
   localparam logic [7:0] EXC2_RST = 8'hFF;
   localparam logic [3:0] ROUTE_OFF = 4'hF;
   localparam logic [3:0] MAG_OFF = 4'h0;
   localparam logic [3:0] MAG_MAX = 4'h9;
   // ****************************************
   // timing
   // ****************************************
   localparam int SYS_MHZ = 100;
   localparam int MOD_KHZ = 4096;
   localparam int RATE_NUM = 14;
   localparam logic [19:0] DELAY_DEF = 20'h0001C;
   localparam logic [3:0] RATE_2000 = 4'hC;
   localparam logic [3:0] RATE_4000 = 4'hD;
   localparam logic [19:0] LL_FIRST_2000 = 20'd336;
   localparam logic [19:0] LL_FIRST_4000 = 20'd208;
   localparam logic [19:0] S3_FIRST_2P5 = 20'd614530;
   localparam logic [19:0] S3_FIRST_4000 = 20'd464;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FIRST = 4'b0010,
      ST_SECOND = 4'b0100,
      ST_NEXT = 4'b1000
   } ccs_state_t;
endpackage : ccs_pkg

// ---- rtl/ccs_pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement-based change detect
// Assumes: input is asynchronous to clk_sys
// Notes: first stage read only by the second
`timescale 1ns/1ps
module ccs_pin_sync (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic level,
   output logic rise
);
   logic s1, s2, s3;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
         rise <= 1'b0;
      end else if (clkEn) begin
         s1 <= pinIn;
         s2 <= s1;
         s3 <= s2;
         rise <= 1'b0;
         if (s2 == s3 && s3 != level) begin
            level <= s3;
            rise <= s3;
         end
      end
   end
endmodule // ccs_pin_sync

// ---- dv/ccs_modulator_model.sv ----
// Purpose: modulator and front-end stand-in for the chopped sequencer
// Assumes: free-running 4.096 MHz modulator clock
// Notes: each sample carries a fixed offset that only chopping removes
`timescale 1ns/1ps
module ccs_modulator_model #(
   parameter logic [23:0] SIGNAL = 24'h001000,
   parameter logic [23:0] OFFSET = 24'h000300
) (
   output logic modClk,
   input wire logic polarityInv,
   output logic [23:0] convData
);
   initial begin
      modClk = 1'b0;
      forever #122.07 modClk = ~modClk;
   end
   // reversing the input flips the signal but not the offset
   assign convData = polarityInv ? OFFSET - SIGNAL : OFFSET + SIGNAL;
endmodule // ccs_modulator_model

// ---- dv/ccs_sequencer_bench.sv ----
// Purpose: self-checking bench for the chopped conversion sequencer
// Assumes: fastest rate index, modulator model on the far side
// Notes: conversion lengths are counted in modulator rising edges
`timescale 1ns/1ps
module ccs_sequencer_bench;
   import ccs_pkg::*;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, convTrigger, modClk;
   logic startCmd, refEnable, polarityInv, convActive, dataReady;
   logic clkEn;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [23:0] convData, chopResult;
   logic [3:0] excite_magnitude, excite_source_one, excite_source_two;
   int mismatches = 0;
   int testsRun = 0;
   int modCount = 0;
   localparam logic [23:0] SIGNAL = 24'h001000;
   localparam logic [7:0] CHOP_LL = 8'h80 | {4'h0, RATE_4000};
   // ****************************************
   // clock, design and far side
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge modClk) modCount++;
   ccs_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convTrigger(convTrigger), .modClk(modClk),
      .startCmd(startCmd), .convData(convData), .refEnable(refEnable),
      .polarityInv(polarityInv), .convActive(convActive), .dataReady(dataReady),
      .chopResult(chopResult), .excite_magnitude(excite_magnitude),
      .excite_source_one(excite_source_one), .excite_source_two(excite_source_two));
   ccs_modulator_model #(.SIGNAL(SIGNAL), .OFFSET(24'h000300)) model (.modClk(modClk),
      .polarityInv(polarityInv), .convData(convData));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic report_and_stop;
      $display("counts: %0d compared, %0d mismatched", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: pready %h expected %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, exp);
      check({31'h0, err}, {31'h0, expErr});
   endtask
   // waits for a result and judges its length, polarity swap and value
   task automatic wait_data(input int expP, input logic chkFlip);
      int m0;
      int n;
      logic p0;
      logic flip;
      m0 = modCount;
      p0 = polarityInv;
      flip = 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (polarityInv !== p0) flip = 1'b1;
      end while (dataReady !== 1'b1 && n < 60000);
      testsRun++;
      if (modCount - m0 < expP - 2 || modCount - m0 > expP + 2) begin
         mismatches++;
         $display("mismatch at %0t: periods %h expected %h", $time, modCount - m0, expP);
      end
      if (chkFlip) check({31'h0, flip}, 32'h1);
      check({8'h0, chopResult}, {8'h0, SIGNAL});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_reset;
      rchk(ADDR_GAIN, {24'h0, GAIN_RST}, 1'b0);
      rchk(ADDR_RATE, {24'h0, RATE_RST}, 1'b0);
      rchk(ADDR_EXC1, {24'h0, EXC1_RST}, 1'b0);
      rchk(ADDR_EXC2, {24'h0, EXC2_RST}, 1'b0);
      rchk(8'h20, 32'h0, 1'b1);
      check({28'h0, excite_source_one}, {28'h0, ROUTE_OFF});
      check({28'h0, excite_magnitude}, {28'h0, MAG_OFF});
      $display("test reset done");
   endtask
   task automatic test_excite;
      refEnable <= 1'b1;
      wreg(ADDR_EXC1, {28'h0, MAG_MAX});
      wreg(ADDR_EXC2, 32'h33);
      wreg(8'h20, 32'h55);
      repeat (2) @(posedge clk_sys);
      check({28'h0, excite_magnitude}, {28'h0, MAG_MAX});
      check({excite_source_two, excite_source_one}, 8'h33);
      wreg(ADDR_EXC2, 32'h72);
      rchk(ADDR_EXC2, 32'h72, 1'b0);
      check({excite_source_two, excite_source_one}, 8'h72);
      clkEn <= 1'b0;
      refEnable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({28'h0, excite_magnitude}, {28'h0, MAG_MAX});
      clkEn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check({28'h0, excite_magnitude}, 32'h0);
      $display("test excite done");
   endtask
   task automatic test_single(input logic pin, input logic [7:0] rate, input int expP);
      wreg(ADDR_RATE, {24'h0, rate});
      rchk(ADDR_RATE, {24'h0, rate}, 1'b0);
      @(posedge clk_sys);
      if (pin) convTrigger <= 1'b1;
      else startCmd <= 1'b1;
      @(posedge clk_sys);
      startCmd <= 1'b0;
      wait_data(expP, 1'b1);
      check({31'h0, convActive}, 32'h0);
      convTrigger <= 1'b0;
      $display("test single done");
   endtask
   task automatic test_continuous;
      wreg(ADDR_GAIN, 32'h1 << DELAY_LSB);
      wreg(ADDR_RATE, {24'h0, CHOP_LL});
      wreg(ADDR_CTRL, 32'h3);
      wait_data(208 + 2 * 56, 1'b1);
      check({31'h0, convActive}, 32'h1);
      wait_data((208 + 2 * 56) / 2, 1'b0);
      wait_data((208 + 2 * 56) / 2, 1'b0);
      wreg(ADDR_CTRL, 32'h0);
      $display("test continuous done");
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      convTrigger = 1'b0;
      startCmd = 1'b0;
      refEnable = 1'b0;
      clkEn = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      test_reset();
      test_excite();
      test_single(1'b0, CHOP_LL, 208 + 2 * 28);
      test_single(1'b1, CHOP_LL | 8'h10, 464 + 2 * 28);
      test_continuous();
      report_and_stop();
   end
   initial begin
      #900000;
      mismatches++;
      report_and_stop();
   end
endmodule // ccs_sequencer_bench
